// [rtl/acs_sequencer_ctrl.sv]
/*
 Sequencer control for a four-sequencer converter: AHB-Lite register
 slave, sticky FIFO fault flags, trigger-source multiplexer, priority
 dispatch and a masked level interrupt.
 Assumes trigger inputs are one-cycle pulses from logic on hclk and the
 converter answers each start with one result strobe tagged by sequencer.
*/
`timescale 1ns/1ps

// What this block does
// RULE_01: A result written into a full FIFO is dropped and sets that sequencer's overflow bit.
// RULE_02: Overflow bits clear only by writing one to them and reset to zero.
// RULE_03: Reading an empty FIFO returns zero, keeps the pointers and sets the underflow bit.
// RULE_04: Underflow bits clear by writing one to them and reset to zero.
// RULE_05: Each sequencer has its own four-bit trigger-source select field.
// RULE_06: The select fields sit at bits 3:0, 7:4, 11:8, 15:12, reset to zero, one encoding.
// RULE_07: Codes 0 processor, 1 GPIO, 2 continuous, 3 RTC, 4-6 timers; 7 is reserved.
// RULE_08: Codes 8-A PWM units, B reserved, C-F analog comparators.
// RULE_09: Two-bit priority fields at 1:0, 5:4, 9:8, 13:12 reset to 0, 1, 2 and 3.
// RULE_10: Priority value zero is served first and three last.
// RULE_11: Software keeps all priority values distinct; duplicates give undefined order.
// RULE_12: Unused upper bits of these registers read zero and ignore writes.
// RULE_13: Sequencers triggered together are started in priority order.
// RULE_14: Writing one to an initiate bit starts an enabled, processor-sourced sequencer.
// RULE_15: Writing zero to a flag does nothing and a new event beats a same-cycle clear.
module acs_sequencer_ctrl
(
	// Clock and reset
	input  wire logic                       hclk,
	input  wire logic                       hresetn,
	// AHB-Lite slave
	input  wire logic                       hsel,
	input  wire logic [31:0]                haddr,
	input  wire logic [1:0]                 htrans,
	input  wire logic                       hwrite,
	input  wire logic [2:0]                 hsize,
	input  wire logic [31:0]                hwdata,
	input  wire logic                       hready,
	output logic                            hreadyout,
	output logic      [31:0]                hrdata,
	output logic                            hresp,
	// Trigger sources
	input  wire logic                       gpio_trig,
	input  wire logic                       rtc_trig,
	input  wire logic [2:0]                 timer_trig,
	input  wire logic [2:0]                 pwm_trig,
	input  wire logic [3:0]                 acmp_trig,
	// Converter
	input  wire logic                       conv_busy,
	output logic                            conv_start,
	output logic      [1:0]                 conv_seq,
	input  wire logic                       res_valid,
	input  wire logic [1:0]                 res_seq,
	input  wire logic [acs_pkg::RES_W-1:0]  res_data,
	// Interrupt
	output logic                            irq
);

	acs_pkg::acs_state_t                           st_reg;
	acs_pkg::acs_state_t                           st_next;
	logic [acs_pkg::NSEQ-1:0]                      fifo_rd;
	logic [acs_pkg::NSEQ-1:0]                      fifo_wr;
	logic [acs_pkg::NSEQ-1:0][acs_pkg::RES_W-1:0]  fifo_data;
	logic [acs_pkg::NSEQ-1:0]                      ovf_evt;
	logic [acs_pkg::NSEQ-1:0]                      unf_evt;
	logic [15:0]                                   src_vec;
	logic                                          dphase;
	logic                                          wr_now;
	logic                                          rd_now;
	logic [2:0]                                    pick;
	logic [acs_pkg::NSEQ-1:0]                      trig_hit;

	// RULE_07: code to event line
	// RULE_08: code to event line
	function automatic logic trig_decode(input logic [3:0] code, input logic [15:0] srcs);
		return srcs[code];
	endfunction

	// Returns {found, index} of the pending sequencer with smallest priority value
	function automatic logic [2:0] prio_pick(input logic [3:0] pend, input logic [7:0] pri);
		logic       found;
		logic [1:0] best_idx;
		logic [1:0] best_pri;
		found    = 1'b0;
		best_idx = 2'h0;
		best_pri = 2'h3;
		for (int i = 0; i < acs_pkg::NSEQ; i++)
		begin
			// RULE_10: lower value served first
			if (pend[i] && (!found || pri[2*i +: 2] < best_pri))
			begin
				found    = 1'b1;
				best_idx = 2'(i);
				best_pri = pri[2*i +: 2];
			end
		end
		return {found, best_idx};
	endfunction

	assign dphase = st_reg.ap_valid && !st_reg.hready_out;
	assign wr_now = dphase && st_reg.ap_write;
	assign rd_now = dphase && !st_reg.ap_write;
	assign pick   = prio_pick(st_reg.pending, st_reg.pri);

	// RULE_07: processor and reserved codes carry no event
	// RULE_08: reserved code carries no event
	assign src_vec = {acmp_trig, 1'b0, pwm_trig, 1'b0, timer_trig, rtc_trig,
		1'b1, gpio_trig, 1'b0};

	genvar g;
	generate
		for (g = 0; g < acs_pkg::NSEQ; g++)
		begin : g_seq
			assign fifo_wr[g]  = res_valid && (res_seq == 2'(g));
			assign fifo_rd[g]  = rd_now &&
				(st_reg.ap_addr == acs_pkg::OFF_FIFO_BASE + 8'(4*g));
			// RULE_05: own select per sequencer
			assign trig_hit[g] = st_reg.enable[g] &&
				trig_decode(st_reg.tsel[acs_pkg::TSEL_W*g +: acs_pkg::TSEL_W], src_vec);

			acs_seq_fifo u_fifo
			(
				.hclk    (hclk),
				.hresetn (hresetn),
				.wr_en   (fifo_wr[g]),
				.wr_data (res_data),
				.rd_en   (fifo_rd[g]),
				.rd_data (fifo_data[g]),
				.ovf_evt (ovf_evt[g]),
				.unf_evt (unf_evt[g])
			);
		end
	endgenerate

	always_comb
	begin
		logic [3:0] init_bits;
		logic [3:0] pend;
		st_next            = st_reg;
		init_bits          = 4'h0;
		pend               = 4'h0;
		st_next.conv_start = 1'b0;

		// Address phase capture
		if (hsel && htrans[1] && hready)
		begin
			st_next.ap_valid   = 1'b1;
			st_next.ap_write   = hwrite;
			st_next.ap_addr    = {haddr[7:2], 2'b00};
			st_next.hready_out = 1'b0;
		end
		else if (dphase)
		begin
			st_next.ap_valid   = 1'b0;
			st_next.hready_out = 1'b1;
		end
		else if (st_reg.hready_out)
			st_next.ap_valid = 1'b0;

		// Register writes, data phase
		if (wr_now)
		begin
			unique case (st_reg.ap_addr)
				// RULE_02: write one clears
				// RULE_15: zero bits no effect
				acs_pkg::OFF_OVERFLOW:   st_next.ovf = st_reg.ovf & ~hwdata[3:0];
				// RULE_04: write one clears
				acs_pkg::OFF_UNDERFLOW:  st_next.unf = st_reg.unf & ~hwdata[3:0];
				// RULE_06: fields 15:0, rest dropped
				acs_pkg::OFF_TRIG_SEL:   st_next.tsel = hwdata[15:0];
				// RULE_09: fields at stride four
				acs_pkg::OFF_PRIORITY:
					st_next.pri = {hwdata[13:12], hwdata[9:8], hwdata[5:4], hwdata[1:0]};
				acs_pkg::OFF_INITIATE:   init_bits = hwdata[3:0];
				acs_pkg::OFF_SEQ_ENABLE: st_next.enable = hwdata[3:0];
				acs_pkg::OFF_INT_STATUS:
					st_next.int_status = st_reg.int_status & ~hwdata[7:0];
				acs_pkg::OFF_INT_MASK:   st_next.int_mask = hwdata[7:0];
				default:                 st_next.ovf = st_next.ovf;
			endcase
		end

		// Register reads, data phase
		if (rd_now)
		begin
			st_next.hrdata = 32'h0000_0000;
			unique case (st_reg.ap_addr)
				// RULE_12: upper bits read zero
				acs_pkg::OFF_OVERFLOW:   st_next.hrdata = {28'h0, st_reg.ovf};
				acs_pkg::OFF_UNDERFLOW:  st_next.hrdata = {28'h0, st_reg.unf};
				acs_pkg::OFF_TRIG_SEL:   st_next.hrdata = {16'h0, st_reg.tsel};
				acs_pkg::OFF_PRIORITY:
					st_next.hrdata = {18'h0, st_reg.pri[7:6], 2'h0, st_reg.pri[5:4], 2'h0,
						st_reg.pri[3:2], 2'h0, st_reg.pri[1:0]};
				acs_pkg::OFF_SEQ_ENABLE: st_next.hrdata = {28'h0, st_reg.enable};
				acs_pkg::OFF_INT_STATUS: st_next.hrdata = {24'h0, st_reg.int_status};
				acs_pkg::OFF_INT_MASK:   st_next.hrdata = {24'h0, st_reg.int_mask};
				default:
				begin
					for (int i = 0; i < acs_pkg::NSEQ; i++)
						if (fifo_rd[i])
							st_next.hrdata = {20'h0, fifo_data[i]};
				end
			endcase
		end

		// RULE_01: sticky overflow set
		// RULE_15: set wins over clear
		st_next.ovf        = st_next.ovf | ovf_evt;
		// RULE_03: sticky underflow set
		st_next.unf        = st_next.unf | unf_evt;
		st_next.int_status = st_next.int_status | {unf_evt, ovf_evt};
		st_next.irq        = |(st_next.int_status & st_next.int_mask);

		// Dispatch one pending sequencer when the converter is free
		pend = st_reg.pending;
		// RULE_13: highest priority first
		if (pick[2] && !conv_busy && !st_reg.conv_start)
		begin
			pend[pick[1:0]]    = 1'b0;
			st_next.conv_start = 1'b1;
			st_next.conv_seq   = pick[1:0];
		end
		for (int i = 0; i < acs_pkg::NSEQ; i++)
		begin
			// RULE_14: initiate needs enable and processor source
			if (init_bits[i] && st_reg.enable[i] &&
				st_reg.tsel[acs_pkg::TSEL_W*i +: acs_pkg::TSEL_W] == acs_pkg::TRG_PROCESSOR)
				pend[i] = 1'b1;
		end
		st_next.pending = (pend | trig_hit) & st_next.enable;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_reg            <= '0;
			st_reg.hready_out <= 1'b1;
			// RULE_06: selects reset to zero
			st_reg.tsel       <= acs_pkg::RST_TRIG_SEL;
			// RULE_09: priorities reset 0,1,2,3
			st_reg.pri        <= acs_pkg::RST_PRIORITY;
			st_reg.ovf        <= acs_pkg::RST_FLAGS;
			st_reg.unf        <= acs_pkg::RST_FLAGS;
			st_reg.enable     <= acs_pkg::RST_ENABLE;
			st_reg.int_status <= acs_pkg::RST_INT;
			st_reg.int_mask   <= acs_pkg::RST_INT;
		end
		else
			st_reg <= st_next;
	end

	assign hreadyout  = st_reg.hready_out;
	assign hrdata     = st_reg.hrdata;
	assign hresp      = 1'b0;
	assign conv_start = st_reg.conv_start;
	assign conv_seq   = st_reg.conv_seq;
	assign irq        = st_reg.irq;

endmodule // acs_sequencer_ctrl

// [rtl/acs_pkg.sv]
/*
 Package for the converter sequencer control block: register offsets,
 reset values, field widths, trigger-source codes and the two state records.
 Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
*/
package acs_pkg;

	localparam int NSEQ       = 4;
	localparam int RES_W      = 12;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_AW    = 3;

	// Register byte offsets
	localparam logic [7:0] OFF_OVERFLOW   = 8'h18;
	localparam logic [7:0] OFF_TRIG_SEL   = 8'h1C;
	localparam logic [7:0] OFF_UNDERFLOW  = 8'h20;
	localparam logic [7:0] OFF_PRIORITY   = 8'h24;
	localparam logic [7:0] OFF_INITIATE   = 8'h28;
	localparam logic [7:0] OFF_SEQ_ENABLE = 8'h30;
	localparam logic [7:0] OFF_INT_STATUS = 8'h34;
	localparam logic [7:0] OFF_INT_MASK   = 8'h38;
	localparam logic [7:0] OFF_FIFO_BASE  = 8'h40;

	// Reset values
	localparam logic [3:0]  RST_FLAGS    = 4'h0;
	localparam logic [15:0] RST_TRIG_SEL = 16'h0000;
	localparam logic [7:0]  RST_PRIORITY = 8'hE4;
	localparam logic [3:0]  RST_ENABLE   = 4'h0;
	localparam logic [7:0]  RST_INT      = 8'h00;

	// Field layout
	localparam int TSEL_W     = 4;
	localparam int PRI_W      = 2;
	localparam int PRI_STRIDE = 4;

	// Trigger-source codes
	localparam logic [3:0] TRG_PROCESSOR  = 4'h0;
	localparam logic [3:0] TRG_GPIO       = 4'h1;
	localparam logic [3:0] TRG_CONTINUOUS = 4'h2;
	localparam logic [3:0] TRG_RTC        = 4'h3;
	localparam logic [3:0] TRG_TIMER0     = 4'h4;
	localparam logic [3:0] TRG_RSVD0      = 4'h7;
	localparam logic [3:0] TRG_PWM0       = 4'h8;
	localparam logic [3:0] TRG_RSVD1      = 4'hB;
	localparam logic [3:0] TRG_ACMP0      = 4'hC;

	typedef struct packed {
		logic                  ap_valid;
		logic                  ap_write;
		logic [7:0]            ap_addr;
		logic                  hready_out;
		logic [31:0]           hrdata;
		logic [NSEQ-1:0]       ovf;
		logic [NSEQ-1:0]       unf;
		logic [15:0]           tsel;
		logic [7:0]            pri;
		logic [NSEQ-1:0]       enable;
		logic [2*NSEQ-1:0]     int_status;
		logic [2*NSEQ-1:0]     int_mask;
		logic                  irq;
		logic [NSEQ-1:0]       pending;
		logic                  conv_start;
		logic [1:0]            conv_seq;
	} acs_state_t;

	typedef struct packed {
		logic [FIFO_DEPTH-1:0][RES_W-1:0] mem;
		logic [FIFO_AW-1:0]               wptr;
		logic [FIFO_AW-1:0]               rptr;
		logic [FIFO_AW:0]                 count;
	} acs_fifo_state_t;

endpackage

// [rtl/acs_seq_fifo.sv]
/*
 One sequencer result FIFO. Drops a write when full and reports it;
 a read when empty returns zeros, keeps the pointers and reports it.
 Assumes write and read strobes are one-cycle pulses on hclk.
*/
`timescale 1ns/1ps
module acs_seq_fifo
(
	// Clock and reset
	input  wire logic                       hclk,
	input  wire logic                       hresetn,
	// Write side
	input  wire logic                       wr_en,
	input  wire logic [acs_pkg::RES_W-1:0]  wr_data,
	// Read side
	input  wire logic                       rd_en,
	output logic      [acs_pkg::RES_W-1:0]  rd_data,
	// Fault events
	output logic                            ovf_evt,
	output logic                            unf_evt
);

	acs_pkg::acs_fifo_state_t st_reg;
	acs_pkg::acs_fifo_state_t st_next;
	logic                     full;
	logic                     empty;

	always_comb
	begin
		st_next = st_reg;
		full    = (st_reg.count == 4'(acs_pkg::FIFO_DEPTH));
		empty   = (st_reg.count == 4'h0);
		// RULE_01: drop when full
		ovf_evt = wr_en && full;
		// RULE_03: empty read flagged
		unf_evt = rd_en && empty;
		// RULE_03: zeros, pointers held
		rd_data = empty ? '0 : st_reg.mem[st_reg.rptr];
		if (wr_en && !full)
		begin
			st_next.mem[st_reg.wptr] = wr_data;
			st_next.wptr             = st_reg.wptr + 3'h1;
		end
		if (rd_en && !empty)
			st_next.rptr = st_reg.rptr + 3'h1;
		st_next.count = st_reg.count + 4'((wr_en && !full) ? 1 : 0)
			- 4'((rd_en && !empty) ? 1 : 0);
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

endmodule // acs_seq_fifo

// [verif/acs_ctrl_properties.sv]
/*
 Port checker for the sequencer control block.
 Assumes hready is fed back from hreadyout by the bus fabric.
*/
`timescale 1ns/1ps
module acs_ctrl_properties
(
	// Bus
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic        hresp,
	// Converter and interrupt
	input wire logic        conv_busy,
	input wire logic        conv_start,
	input wire logic [1:0]  conv_seq,
	input wire logic        res_valid,
	input wire logic        irq
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	logic take;
	assign take = hsel && htrans[1] && hready;
	sequence s_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	okay_resp_a: assert property (hresp == 1'b0)
		else $error("hresp not okay");
	wait_state_a: assert property (take |=> s_wait)
		else $error("wait state wrong");
	ready_idle_a: assert property (hreadyout && !take |=> hreadyout)
		else $error("hreadyout fell without transfer");
	read_hold_a: assert property (hreadyout && !take |=> $stable(hrdata))
		else $error("hrdata moved while idle");
	start_pulse_a: assert property (conv_start |=> !conv_start)
		else $error("start longer than one cycle");
	busy_block_a: assert property (conv_start |-> !$past(conv_busy))
		else $error("start while busy");
	seq_hold_a: assert property (!conv_start |-> $stable(conv_seq))
		else $error("conv_seq moved without start");
	irq_cause_a: assert property ($rose(irq) |-> $past(res_valid)
		|| $past(res_valid, 2) || $past(res_valid, 3) || !$past(hreadyout)
		|| !$past(hreadyout, 2) || !$past(hreadyout, 3))
		else $error("irq rose without cause");
endmodule // acs_ctrl_properties

bind acs_sequencer_ctrl acs_ctrl_properties u_props
(
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
	.conv_busy(conv_busy), .conv_start(conv_start), .conv_seq(conv_seq),
	.res_valid(res_valid), .irq(irq)
);

// [verif/acs_conv_model.sv]
/*
 Converter stand-in: busy from each start for LAT cycles, then one result.
 Assumes starts are one-cycle pulses on hclk.
*/
`timescale 1ns/1ps
module acs_conv_model
#(
	parameter int LAT = 3
)
(
	// Clock and reset
	input wire logic                       hclk,
	input wire logic                       hresetn,
	// Start side
	input wire logic                       conv_start,
	input wire logic [1:0]                 conv_seq,
	// Result side
	output logic                           conv_busy,
	output logic                           res_valid,
	output logic      [1:0]                res_seq,
	output logic      [acs_pkg::RES_W-1:0] res_data
);
	int                      cnt;
	logic [acs_pkg::RES_W-1:0] num;
	// Data toggles outside the strobe so a stale sample never matches
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cnt <= 0;
			num <= '0;
			conv_busy <= 1'b0;
			res_valid <= 1'b0;
			res_seq <= 2'h0;
			res_data <= '0;
		end
		else
		begin
			res_valid <= 1'b0;
			res_data <= ~res_data;
			if (conv_start)
			begin
				conv_busy <= 1'b1;
				cnt <= LAT;
				res_seq <= conv_seq;
			end
			else if (cnt == 1)
			begin
				conv_busy <= 1'b0;
				res_valid <= 1'b1;
				res_data <= num + 1'b1;
				num <= num + 1'b1;
				cnt <= 0;
			end
			else if (cnt != 0)
				cnt <= cnt - 1;
		end
	end
endmodule // acs_conv_model

// [verif/adc_sequencer_fifo_trigger_priority_tb_top.sv]
/*
 Self-checking bench for the sequencer control block.
 Assumes one AHB-Lite master (this bench) and the converter stand-in.
*/
`timescale 1ns/1ps
module adc_sequencer_fifo_trigger_priority_tb_top;
	localparam logic [15:0] PINS = 16'hF77A;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0, conv_seq, res_seq;
	logic [15:0] tv = 16'h0000;
	logic hreadyout, hresp, conv_busy, conv_start, res_valid, irq;
	logic [acs_pkg::RES_W-1:0] res_data;
	logic [1:0] sq[$];
	logic [acs_pkg::RES_W-1:0] rq[$];
	int fails = 0, check_count = 0, cyc = 0;

	acs_sequencer_ctrl i_dut
	(
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.gpio_trig(tv[1]), .rtc_trig(tv[3]), .timer_trig(tv[6:4]),
		.pwm_trig(tv[10:8]), .acmp_trig(tv[15:12]), .conv_busy(conv_busy),
		.conv_start(conv_start), .conv_seq(conv_seq), .res_valid(res_valid),
		.res_seq(res_seq), .res_data(res_data), .irq(irq)
	);
	acs_conv_model #(.LAT(3)) i_conv
	(
		.hclk(hclk), .hresetn(hresetn), .conv_start(conv_start),
		.conv_seq(conv_seq), .conv_busy(conv_busy), .res_valid(res_valid),
		.res_seq(res_seq), .res_data(res_data)
	);

	initial forever #20 hclk = ~hclk;

	task automatic summarize();
		if (fails == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Records starts of every sequencer and results of sequencer zero; cuts a hang short
	always @(posedge hclk)
	begin
		cyc++;
		if (conv_start === 1'b1)
			sq.push_back(conv_seq);
		if (res_valid === 1'b1 && res_seq === 2'h0)
			rq.push_back(res_data);
		if (cyc == 20000)
		begin
			fails++;
			summarize();
		end
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask

	task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(n, e, rd);
	endtask

	task automatic pulse(input logic [15:0] v);
		tv <= v;
		@(posedge hclk);
		tv <= 16'h0000;
		repeat (10) @(posedge hclk);
	endtask

	task automatic t_regs();
		rchk("overflow", 8'h18, 32'h0);
		rchk("underflow", 8'h20, 32'h0);
		rchk("trig_sel", 8'h1C, 32'h0);
		rchk("priority", 8'h24, 32'h3210);
		xfer(1'b1, 8'h2C, 32'hFFFFFFFF);
		rchk("unmapped", 8'h2C, 32'h0);
		xfer(1'b1, 8'h1C, 32'hFFFFFFFF);
		rchk("trig_sel", 8'h1C, 32'h0000FFFF);
		xfer(1'b1, 8'h1C, 32'h00005A3C);
		rchk("trig_sel", 8'h1C, 32'h00005A3C);
		xfer(1'b1, 8'h24, 32'hFFFFFFFF);
		rchk("priority", 8'h24, 32'h3333);
	endtask

	task automatic t_underflow();
		rchk("fifo1", 8'h44, 32'h0);
		rchk("underflow", 8'h20, 32'h2);
		rchk("int_status", 8'h34, 32'h20);
		chk("irq", 32'h0, {31'h0, irq});
		xfer(1'b1, 8'h38, 32'h20);
		repeat (3) @(posedge hclk);
		chk("irq", 32'h1, {31'h0, irq});
		xfer(1'b1, 8'h20, 32'h0);
		rchk("underflow", 8'h20, 32'h2);
		xfer(1'b1, 8'h20, 32'h2);
		rchk("underflow", 8'h20, 32'h0);
		xfer(1'b1, 8'h34, 32'h20);
		repeat (3) @(posedge hclk);
		chk("irq", 32'h0, {31'h0, irq});
	endtask

	task automatic t_triggers();
		xfer(1'b1, 8'h30, 32'h1);
		for (int c = 1; c < 16; c++)
		begin
			if (PINS[c])
			begin
				xfer(1'b1, 8'h1C, 32'(c));
				sq.delete();
				pulse(PINS & ~(16'h1 << c));
				chk("foreign", 32'h0, 32'(sq.size()));
				pulse(16'h1 << c);
				chk("starts", 32'h1, 32'(sq.size()));
				chk("seq", 32'h0, {30'h0, sq[0]});
			end
		end
		rchk("overflow", 8'h18, 32'h1);
		xfer(1'b1, 8'h18, 32'h0);
		rchk("overflow", 8'h18, 32'h1);
		for (int i = 0; i < 8; i++)
			rchk("fifo0", 8'h40, 32'(rq[i]));
		rchk("fifo0", 8'h40, 32'h0);
		xfer(1'b1, 8'h18, 32'h1);
		rchk("overflow", 8'h18, 32'h0);
		xfer(1'b1, 8'h1C, 32'h2);
		sq.delete();
		repeat (30) @(posedge hclk);
		xfer(1'b1, 8'h30, 32'h0);
		chk("continuous", 32'h1, 32'(sq.size() >= 3));
	endtask

	task automatic t_order(input logic [31:0] pri, input logic [31:0] e);
		xfer(1'b1, 8'h30, 32'h0);
		xfer(1'b1, 8'h1C, 32'h0);
		xfer(1'b1, 8'h24, pri);
		sq.delete();
		xfer(1'b1, 8'h28, 32'hF);
		repeat (10) @(posedge hclk);
		chk("disabled", 32'h0, 32'(sq.size()));
		xfer(1'b1, 8'h30, 32'hF);
		xfer(1'b1, 8'h28, 32'hF);
		repeat (40) @(posedge hclk);
		chk("order", e, {24'h0, sq[0], sq[1], sq[2], sq[3]});
	endtask

	initial
	begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs();
		t_underflow();
		t_triggers();
		t_order(32'h0123, 32'hE4);
		t_order(32'h3210, 32'h1B);
		summarize();
	end
endmodule // adc_sequencer_fifo_trigger_priority_tb_top
